// ---- verif/rtc_pulse_src.sv ----
`timescale 1ns/1ps
module rtc_pulse_src #(
   parameter int HALF = 4
) (
   input wire logic ref_clk_i,
   output logic pin_o
);
   // Pin idles low
   initial pin_o = 1'b0;
   // Hold one level for a full phase
   task automatic level(input logic v);
      @(posedge ref_clk_i);
      pin_o <= v;
      repeat (HALF) @(posedge ref_clk_i);
   endtask : level
   // Train of high-low pulses
   task automatic burst(input int n);
      repeat (n) begin
         level(1'b1);
         level(1'b0);
      end
   endtask : burst
endmodule : rtc_pulse_src

// ---- verif/rtc_top_test.sv ----
`timescale 1ns/1ps
module rtc_top_test;
   import rtc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic pin;
   logic irq_o;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [7:0] v;

   // Clock
   always #5 ref_clk_i = ~ref_clk_i;

   rtc_top u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .ext_count_input_i(pin), .irq_o(irq_o));
   rtc_pulse_src u_src (.ref_clk_i(ref_clk_i), .pin_o(pin));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   // Compare helpers
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_rng(input string nm, input logic [7:0] lo,
                          input logic [7:0] hi, input logic [7:0] g);
      checks_done++;
      if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1)) begin
         n_mismatch++;
         $display("unexpected %s exp %h..%h got %h", nm, lo, hi, g);
      end
   endtask : chk_rng

   // Register bus cycles
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask : rd
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : wt

   task automatic t_reset();
      logic [7:0] a[6] = '{8'h01, 8'h0b, 8'h0c, 8'h10, 8'h11, 8'h20};
      foreach (a[i]) begin
         rd(a[i]);
         chk("reset value", 8'h00, v);
      end
      chk("irq", 8'h00, {7'h00, irq_o});
      $display("reset test done");
   endtask : t_reset

   task automatic t_regs();
      wr(RTC_OFS_CTRL, 8'hff);
      rd(RTC_OFS_CTRL);
      chk("control", 8'h7f, v);
      wr(RTC_OFS_COUNT, 8'ha5);
      rd(RTC_OFS_COUNT);
      chk("count", 8'ha5, v);
      wr(RTC_OFS_IRQ_EN, 8'hff);
      rd(RTC_OFS_IRQ_EN);
      chk("enable", 8'hff, v);
      wr(RTC_OFS_RELOAD, 8'h5a);
      rd(RTC_OFS_RELOAD);
      chk("reload", 8'h5a, v);
      wr(8'h20, 8'h33);
      rd(8'h20);
      chk("unmapped", 8'h00, v);
      $display("register test done");
   endtask : t_regs

   task automatic t_ovf();
      wr(RTC_OFS_CTRL, 8'h40);
      wr(RTC_OFS_IRQ_EN, 8'h10);
      wr(RTC_OFS_RELOAD, 8'h80);
      wr(RTC_OFS_COUNT, 8'hff);
      wr(RTC_OFS_CTRL, 8'h00);
      wt(12);
      chk("irq", 8'h01, {7'h00, irq_o});
      wr(RTC_OFS_CTRL, 8'h40);
      rd(RTC_OFS_COUNT);
      chk_rng("count", 8'h80, 8'h86, v);
      wr(RTC_OFS_IRQ_PEND, 8'hff);
      rd(RTC_OFS_IRQ_PEND);
      chk("pending", 8'h10, v);
      wr(RTC_OFS_IRQ_PEND, 8'hef);
      rd(RTC_OFS_IRQ_PEND);
      chk("pending", 8'h00, v);
      chk("irq", 8'h00, {7'h00, irq_o});
      wr(RTC_OFS_IRQ_EN, 8'h00);
      wr(RTC_OFS_COUNT, 8'hff);
      wr(RTC_OFS_CTRL, 8'h00);
      wt(12);
      wr(RTC_OFS_CTRL, 8'h40);
      chk("irq", 8'h00, {7'h00, irq_o});
      rd(RTC_OFS_IRQ_PEND);
      chk("pending", 8'h10, v);
      wr(RTC_OFS_IRQ_PEND, 8'hef);
      $display("overflow test done");
   endtask : t_ovf

   task automatic t_halt();
      wr(RTC_OFS_COUNT, 8'h33);
      wt(100);
      rd(RTC_OFS_COUNT);
      chk("count", 8'h33, v);
      wr(RTC_OFS_CTRL, 8'h00);
      wt(40);
      rd(RTC_OFS_COUNT);
      chk_rng("count", 8'h42, 8'h48, v);
      $display("halt test done");
   endtask : t_halt

   task automatic t_psc();
      logic [3:0] c[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                            4'h7, 4'h8, 4'hf};
      int r;
      foreach (c[i]) begin
         r = c[i][3] ? 256 : (1 << c[i]);
         wr(RTC_OFS_CTRL, {4'h0, c[i]});
         wr(RTC_OFS_COUNT, 8'h00);
         wt(16 * r);
         rd(RTC_OFS_COUNT);
         chk_rng("rate", 8'h07, 8'h09, v);
      end
      $display("prescale test done");
   endtask : t_psc

   task automatic t_clr();
      wr(RTC_OFS_CTRL, 8'h08);
      wr(RTC_OFS_COUNT, 8'h00);
      wt(300);
      wr(RTC_OFS_CTRL, 8'h08);
      wt(300);
      rd(RTC_OFS_COUNT);
      chk("count", 8'h00, v);
      wt(250);
      rd(RTC_OFS_COUNT);
      chk("count", 8'h01, v);
      wr(RTC_OFS_COUNT, 8'h05);
      wt(300);
      wr(RTC_OFS_COUNT, 8'h05);
      wt(300);
      rd(RTC_OFS_COUNT);
      chk("count", 8'h05, v);
      $display("prescaler clear test done");
   endtask : t_clr

   task automatic t_ext();
      wr(RTC_OFS_CTRL, 8'h10);
      wr(RTC_OFS_COUNT, 8'h00);
      u_src.level(1'b1);
      wt(10);
      rd(RTC_OFS_COUNT);
      chk("rise", 8'h01, v);
      u_src.level(1'b0);
      wt(10);
      rd(RTC_OFS_COUNT);
      chk("rise", 8'h01, v);
      wr(RTC_OFS_CTRL, 8'h30);
      wr(RTC_OFS_COUNT, 8'h00);
      u_src.level(1'b1);
      wt(10);
      rd(RTC_OFS_COUNT);
      chk("fall", 8'h00, v);
      u_src.level(1'b0);
      u_src.burst(5);
      wt(10);
      rd(RTC_OFS_COUNT);
      chk("fall", 8'h06, v);
      $display("external input test done");
   endtask : t_ext

   // Main sequence
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_regs();
      t_ovf();
      t_halt();
      t_psc();
      t_clr();
      t_ext();
      print_verdict();
   end

   // Hang guard
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         print_verdict();
      end
   end
endmodule : rtc_top_test

// ---- verilog/rtc_ext_sync.sv ----
`timescale 1ns/1ps
module rtc_ext_sync (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic sample_en_i,
   input wire logic pin_i,
   input wire logic fall_sel_i,
   output logic edge_o
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic edge_q;

   // Synchroniser and history, stepped at instruction rate
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else if (sample_en_i) begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Selected edge as a one-cycle pulse
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         edge_q <= 1'b0;
      end else begin
         edge_q <= sample_en_i && (fall_sel_i ? (s3_q && !s2_q)
                                             : (s2_q && !s3_q));
      end
   end

   assign edge_o = edge_q;
endmodule : rtc_ext_sync

// ---- verilog/rtc_pkg.sv ----
package rtc_pkg;
   // Register bus shape
   localparam int unsigned RTC_AW = 8;
   localparam int unsigned RTC_DW = 8;
   // Register offsets
   localparam logic [7:0] RTC_OFS_COUNT = 8'h01;
   localparam logic [7:0] RTC_OFS_IRQ_EN = 8'h0b;
   localparam logic [7:0] RTC_OFS_IRQ_PEND = 8'h0c;
   localparam logic [7:0] RTC_OFS_RELOAD = 8'h10;
   localparam logic [7:0] RTC_OFS_CTRL = 8'h11;
   // Reset values
   localparam logic [7:0] RTC_RST_COUNT = 8'h00;
   localparam logic [7:0] RTC_RST_IRQ_EN = 8'h00;
   localparam logic [7:0] RTC_RST_RELOAD = 8'h00;
   localparam logic [7:0] RTC_RST_CTRL = 8'h00;
   // Field positions
   localparam int unsigned RTC_BIT_OVF = 4;
   localparam int unsigned RTC_BIT_HALT = 6;
   localparam int unsigned RTC_BIT_EDGE = 5;
   localparam int unsigned RTC_BIT_SRC = 4;
   localparam int unsigned RTC_PSC_MSB = 3;
   // Implemented control bits, top count value, prescaler width
   localparam logic [7:0] RTC_CTRL_MASK = 8'h7f;
   localparam logic [7:0] RTC_CNT_MAX = 8'hff;
   localparam int unsigned RTC_PSC_W = 8;

   // Count source selection
   typedef enum logic {
      RTC_SRC_INSTR = 1'b0,
      RTC_SRC_EXT = 1'b1
   } rtc_src_t;

   // Low-bit mask of the prescaler for a division code
   function automatic logic [7:0] rtc_psc_mask(input logic [3:0] code);
      logic [7:0] m;
      m = 8'hff;
      if (!code[3]) begin
         m = 8'((9'h001 << code[2:0]) - 9'h001);
      end
      return m;
   endfunction : rtc_psc_mask
endpackage : rtc_pkg

// ---- verilog/rtc_prescaler.sv ----
`timescale 1ns/1ps
module rtc_prescaler #(
   parameter int unsigned PW = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   rtc_tick_if.psc tk
);
   import rtc_pkg::*;

   logic [PW-1:0] cnt_q;
   logic tick_q;
   logic hit;

   // Division codes need exactly eight prescaler bits
   if (PW != RTC_PSC_W) begin : g_bad_width
      $error("rtc_prescaler: PW must be 8");
   end

   // Last source tick of a division period
   assign hit = tk.src_tick && ((cnt_q | ~rtc_psc_mask(tk.code)) == 8'hff);

   // Prescaler count, cleared by control and count register writes
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
      end else if (tk.clr) begin
         cnt_q <= '0;
      end else if (tk.src_tick) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // One-cycle tick at period end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= hit && !tk.clr;
      end
   end

   assign tk.count_tick = tick_q;
   assign tk.pcnt = cnt_q;
endmodule : rtc_prescaler

// ---- verilog/rtc_tick_if.sv ----
`timescale 1ns/1ps
interface rtc_tick_if;
   logic src_tick;
   logic clr;
   logic [3:0] code;
   logic count_tick;
   logic [7:0] pcnt;

   modport ctrl (output src_tick, output clr, output code,
                 input count_tick, input pcnt);
   modport psc (input src_tick, input clr, input code,
                output count_tick, output pcnt);
endinterface : rtc_tick_if

// ---- verilog/rtc_top.sv ----
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module rtc_top (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [rtc_pkg::RTC_AW-1:0] addr_i,
   input wire logic [rtc_pkg::RTC_DW-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [rtc_pkg::RTC_DW-1:0] rdata_o,
   input wire logic ext_count_input_i,
   output logic irq_o
);
   import rtc_pkg::*;

   logic [7:0] count_value_q;
   logic [7:0] count_value_d;
   logic [7:0] reload_value_q;
   logic [7:0] counter_control_q;
   logic [7:0] irq_enable_reg_q;
   logic overflow_flag_q;
   logic overflow_flag_d;
   logic [7:0] rdata_q;
   logic irq_q;
   logic phase_q;
   logic instr_tick;
   logic ext_edge;
   logic count_write_strobe;
   logic ctrl_write;
   logic pend_write;
   logic halt_bit;
   logic rollover;
   rtc_src_t count_source_select;

   rtc_tick_if tk ();

   // Write decode
   assign count_write_strobe = wr_i && (addr_i == RTC_OFS_COUNT);
   assign ctrl_write = wr_i && (addr_i == RTC_OFS_CTRL);
   assign pend_write = wr_i && (addr_i == RTC_OFS_IRQ_PEND);

   // Control field views
   assign halt_bit = counter_control_q[RTC_BIT_HALT];
   assign count_source_select = rtc_src_t'(counter_control_q[RTC_BIT_SRC]);

   // Instruction-cycle phase, one pulse every two clocks
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_q <= 1'b0;
      end else begin
         phase_q <= !phase_q;
      end
   end
   assign instr_tick = phase_q;

   // External pin synchroniser and edge picker
   rtc_ext_sync u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .sample_en_i(instr_tick),
      .pin_i(ext_count_input_i),
      .fall_sel_i(counter_control_q[RTC_BIT_EDGE]),
      .edge_o(ext_edge)
   );

   // Prescaler feed: source choice, halt gating, write clears
   assign tk.src_tick = !halt_bit && ((count_source_select == RTC_SRC_EXT)
                        ? ext_edge : instr_tick);
   assign tk.clr = ctrl_write || count_write_strobe;
   assign tk.code = counter_control_q[RTC_PSC_MSB:0];

   rtc_prescaler #(
      .PW(RTC_PSC_W)
   ) u_psc (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .tk(tk)
   );

   // Rollover when a tick finds the count at its top
   assign rollover = tk.count_tick && !halt_bit && !count_write_strobe
                     && (count_value_q == RTC_CNT_MAX);

   // Next count: write first, then tick
   always_comb begin
      count_value_d = count_value_q;
      if (count_write_strobe) begin
         count_value_d = wdata_i;
      end else if (tk.count_tick && !halt_bit) begin
         if (count_value_q == RTC_CNT_MAX) begin
            count_value_d = reload_value_q;
         end else begin
            count_value_d = count_value_q + 8'h01;
         end
      end
   end

   // Count register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_value_q <= RTC_RST_COUNT;
      end else begin
         count_value_q <= count_value_d;
      end
   end

   // Reload, control and enable registers
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reload_value_q <= RTC_RST_RELOAD;
         counter_control_q <= RTC_RST_CTRL;
         irq_enable_reg_q <= RTC_RST_IRQ_EN;
      end else if (wr_i) begin
         if (addr_i == RTC_OFS_RELOAD) begin
            reload_value_q <= wdata_i;
         end
         if (addr_i == RTC_OFS_CTRL) begin
            counter_control_q <= wdata_i & RTC_CTRL_MASK;
         end
         if (addr_i == RTC_OFS_IRQ_EN) begin
            irq_enable_reg_q <= wdata_i;
         end
      end
   end

   // Overflow flag: set wins, zero written clears
   always_comb begin
      overflow_flag_d = overflow_flag_q;
      if (pend_write && !wdata_i[RTC_BIT_OVF]) begin
         overflow_flag_d = 1'b0;
      end
      if (rollover) begin
         overflow_flag_d = 1'b1;
      end
   end

   // Flag register
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         overflow_flag_q <= 1'b0;
      end else begin
         overflow_flag_q <= overflow_flag_d;
      end
   end

   // Level interrupt, registered
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= overflow_flag_q
                  && irq_enable_reg_q[RTC_BIT_OVF];
      end
   end

   // Read data, valid the cycle after the strobe
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 8'h00;
      end else if (rd_i) begin
         case (addr_i)
            RTC_OFS_COUNT: rdata_q <= count_value_q;
            RTC_OFS_IRQ_EN: rdata_q <= irq_enable_reg_q;
            RTC_OFS_IRQ_PEND:
               rdata_q <= 8'(overflow_flag_q) << RTC_BIT_OVF;
            RTC_OFS_RELOAD: rdata_q <= reload_value_q;
            RTC_OFS_CTRL: rdata_q <= counter_control_q;
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // Ports straight from their flops
   assign rdata_o = rdata_q;
   assign irq_o = irq_q;

   // Checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_cnt_wr;
      wr_i && addr_i == RTC_OFS_COUNT;
   endsequence

   sequence s_ctl_wr;
      wr_i && addr_i == RTC_OFS_CTRL;
   endsequence

   sequence s_top_tick;
      tk.count_tick && !halt_bit && !count_write_strobe
      && count_value_q == RTC_CNT_MAX;
   endsequence

   sequence s_mid_tick;
      tk.count_tick && !halt_bit && !count_write_strobe
      && count_value_q != RTC_CNT_MAX;
   endsequence

   sequence s_ext_idle;
      count_source_select == RTC_SRC_EXT && !ext_edge && !halt_bit;
   endsequence

   cnt_write_a: assert property (
      s_cnt_wr |=> count_value_q == $past(wdata_i))
      else $error("count write not loaded");

   cnt_readback_a: assert property (
      rd_i && addr_i == RTC_OFS_COUNT && !wr_i
      |=> rdata_o == $past(count_value_q))
      else $error("count readback wrong");

   reload_roll_a: assert property (
      s_top_tick |=> count_value_q == $past(reload_value_q)
                     && overflow_flag_q)
      else $error("rollover did not reload");

   flag_noen_a: assert property (
      s_top_tick ##0 !irq_enable_reg_q[RTC_BIT_OVF] |=> overflow_flag_q)
      else $error("flag not set with interrupt off");

   irq_follow_a: assert property (
      overflow_flag_q && irq_enable_reg_q[RTC_BIT_OVF]
      |=> irq_o)
      else $error("interrupt not raised");

   irq_quiet_a: assert property (
      !(overflow_flag_q && irq_enable_reg_q[RTC_BIT_OVF]) |=> !irq_o)
      else $error("spurious interrupt");

   halt_hold_a: assert property (
      halt_bit && !count_write_strobe |=> $stable(count_value_q))
      else $error("count moved while halted");

   halt_psc_a: assert property (
      (halt_bit && !tk.clr) [*3] |-> $stable(tk.pcnt))
      else $error("prescaler moved while halted");

   psc_ctl_clr_a: assert property (
      s_ctl_wr |=> tk.pcnt == 8'h00)
      else $error("control write kept prescaler");

   psc_cnt_clr_a: assert property (
      s_cnt_wr |=> tk.pcnt == 8'h00 && !tk.count_tick)
      else $error("count write kept prescaler");

   step_one_a: assert property (
      s_mid_tick |=> count_value_q == $past(count_value_q) + 8'h01)
      else $error("count did not step by one");

   div_one_a: assert property (
      counter_control_q[3:0] == 4'h0 && tk.src_tick && !tk.clr
      |=> tk.count_tick)
      else $error("divide by one missed tick");

   flag_clear_a: assert property (
      pend_write && wdata_i == 8'hef && !rollover |=> !overflow_flag_q)
      else $error("EFh did not clear flag");

   set_wins_a: assert property (
      pend_write && !wdata_i[RTC_BIT_OVF] && rollover
      |=> overflow_flag_q)
      else $error("clear beat a set");

   one_keeps_a: assert property (
      pend_write && wdata_i[RTC_BIT_OVF] && overflow_flag_q
      |=> overflow_flag_q)
      else $error("writing one cleared flag");

   ext_gate_a: assert property (
      s_ext_idle |=> !tk.count_tick)
      else $error("count tick without pin edge");

   instr_feed_a: assert property (
      count_source_select == RTC_SRC_INSTR && !halt_bit && instr_tick
      && counter_control_q[RTC_PSC_MSB:0] == 4'h0 && !tk.clr
      |=> tk.count_tick)
      else $error("instruction tick not counted");

   div_max_a: assert property (
      counter_control_q[RTC_PSC_MSB] && tk.pcnt != 8'hff
      |=> !tk.count_tick)
      else $error("tick before 256 source ticks");

   ext_rate_a: assert property (
      !instr_tick |=> !ext_edge)
      else $error("pin edge off instruction rate");
endmodule : rtc_top
